// ### addr_cfg_chk.sv
`default_nettype none
module addr_cfg_chk
    import addr_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] strap_offset,
    input wire logic voltage_setting_pin_floating,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_done,
    input wire logic cmd_unsupported,
    input wire logic [6:0] bus_address,
    input wire logic bus_address_valid,
    input wire logic nonvolatile_memory_unlocked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic pw, known;
    // Password write and mapped-code decodes
    assign pw = cmd_valid && cmd_write && cmd_code == CMD_UNLOCK_PASSWORD;
    assign known = cmd_code inside {CMD_PRIMARY_BASE, CMD_SECONDARY_BASE, CMD_UNLOCK_PASSWORD};
    // Answers one cycle after a request, never unprompted
    done_delay_a: assert property (cmd_valid |=> cmd_done) else $error("done late");
    stray_done_a: assert property (!cmd_valid |=> !cmd_done) else $error("stray done");
    unmapped_code_a: assert property (cmd_valid && !known
        |=> cmd_unsupported && cmd_rdata == 16'h0000) else $error("no refusal");
    pw_match_a: assert property (pw && cmd_wdata == UNLOCK_PASSWORD_CODE
        |=> nonvolatile_memory_unlocked) else $error("no unlock");
    pw_wrong_a: assert property (pw && cmd_wdata != UNLOCK_PASSWORD_CODE
        |=> !nonvolatile_memory_unlocked) else $error("no relock");
    lock_hold_a: assert property (!pw |=> $stable(nonvolatile_memory_unlocked))
        else $error("lock moved");
    strap_held_a: assert property (bus_address_valid
        |=> bus_address_valid && $stable(bus_address[3:0])) else $error("strap moved");
    pw_hidden_a: assert property (cmd_valid && !cmd_write && cmd_code == CMD_UNLOCK_PASSWORD
        |=> cmd_rdata == 16'h0000) else $error("password seen");
    cover property (pw);
    cover property ($rose(bus_address_valid));
    cover property (cmd_valid && !known);
endmodule : addr_cfg_chk
`default_nettype wire

// ### addr_cfg_pkg.sv
`default_nettype none
package addr_cfg_pkg;
    // Command codes of the reachable registers
    localparam logic [7:0] CMD_PRIMARY_BASE = 8'hD7;
    localparam logic [7:0] CMD_SECONDARY_BASE = 8'hE2;
    localparam logic [7:0] CMD_UNLOCK_PASSWORD = 8'hDB;
    // Reset values
    localparam logic [7:0] PRIMARY_BASE_RESET = 8'h10;
    localparam logic [7:0] SECONDARY_BASE_RESET = 8'h50;
    localparam logic [15:0] UNLOCK_PASSWORD_CODE = 16'h1234;
    // Field layout of the bus address
    localparam int BASE_FIELD_MSB = 6;
    localparam int BASE_FIELD_LSB = 4;
    localparam int OFFSET_WIDTH = 4;
    localparam int ADDRESS_WIDTH = 7;
    // Strap settling time before sampling
    localparam int CLK_PERIOD_NS = 10;
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_COUNT_WIDTH = 8;
    // Strap sampling sequence, Gray coded
    typedef enum logic [1:0] {
        STRAP_SETTLE = 2'b00,
        STRAP_CAPTURE = 2'b01,
        STRAP_HELD = 2'b11
    } strap_state_t;
endpackage : addr_cfg_pkg
`default_nettype wire

// ### bus_address_config.sv
// Contract
// - Password defaults 1234h; match unlocks memory writes
// - Respond at seven-bit address: base plus offset
// - Upper three bits from selected base bits 6-4
// - Lower four bits equal strap-resistor offset
// - Grounded or shorted voltage pin selects primary base
// - Floating voltage pin selects secondary base
// - Bases reset to 10h and 50h
// - Host reads and writes both base registers
// - Wrong value relocks; reset always relocks
`default_nettype none
module bus_address_config (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [addr_cfg_pkg::OFFSET_WIDTH-1:0] strap_offset,
    input wire logic voltage_setting_pin_floating,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_done,
    output logic cmd_unsupported,
    output logic [addr_cfg_pkg::ADDRESS_WIDTH-1:0] bus_address,
    output logic bus_address_valid,
    output logic nonvolatile_memory_unlocked
);
    import addr_cfg_pkg::*;

    // Synchronised strap levels; the late stage trails the middle one by a clock
    logic [OFFSET_WIDTH-1:0] offset_mid;
    logic [OFFSET_WIDTH-1:0] offset_late;
    logic floating_mid;
    logic floating_late;

    // Straps come from the analog decoder, outside this clock
    // Three flops: a change counts once the last two agree
    strap_sync #(.WIDTH(OFFSET_WIDTH)) offset_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(strap_offset),
        .stage_mid(offset_mid),
        .stage_late(offset_late)
    );

    // The pin state is one bit, so it rides a chain of its own
    strap_sync #(.WIDTH(1)) floating_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(voltage_setting_pin_floating),
        .stage_mid(floating_mid),
        .stage_late(floating_late)
    );

    // Capture sequence and settle counter
    strap_state_t strap_state;
    strap_state_t next_strap_state;
    logic [SETTLE_COUNT_WIDTH-1:0] settle_count;
    logic [SETTLE_COUNT_WIDTH-1:0] next_settle_count;

    // Strap values frozen at capture
    logic [OFFSET_WIDTH-1:0] held_offset;
    logic [OFFSET_WIDTH-1:0] next_held_offset;
    logic held_floating;
    logic next_held_floating;

    // Wait for the straps to settle, then take one agreed sample.
    // The resistor decoder needs time after power-up before its code is
    // trustworthy; sampling early could latch a half-formed offset.
    always_comb begin
        next_strap_state = strap_state;
        next_settle_count = settle_count;
        next_held_offset = held_offset;
        next_held_floating = held_floating;
        unique case (strap_state)
            STRAP_SETTLE: begin
                if (settle_count == SETTLE_COUNT_WIDTH'(STRAP_SETTLE_CYCLES - 1)) begin
                    next_strap_state = STRAP_CAPTURE;
                end else begin
                    next_settle_count = settle_count + 1'b1;
                end
            end
            STRAP_CAPTURE: begin
                // A value counts only once two stages agree
                if (offset_mid == offset_late && floating_mid == floating_late) begin
                    next_held_offset = offset_late;
                    next_held_floating = floating_late;
                    next_strap_state = STRAP_HELD;
                end
            end
            STRAP_HELD: begin
                // Frozen until the next reset so the strap bits of the address never move mid-transfer
                next_strap_state = STRAP_HELD;
            end
            default: begin
                next_strap_state = STRAP_SETTLE;
            end
        endcase
    end

    // Reset clears the capture, so every power-up samples the straps afresh
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_state <= STRAP_SETTLE;
            settle_count <= '0;
            held_offset <= '0;
            held_floating <= 1'b0;
        end else begin
            strap_state <= next_strap_state;
            settle_count <= next_settle_count;
            held_offset <= next_held_offset;
            held_floating <= next_held_floating;
        end
    end

    // Host-visible registers and the lock
    logic [7:0] primary_bus_address_base;
    logic [7:0] secondary_bus_address_base;
    logic unlocked;

    // Next values of the registers and of the registered answer
    logic [7:0] next_primary;
    logic [7:0] next_secondary;
    logic next_unlocked;
    logic [15:0] next_rdata;
    logic next_done;
    logic next_unsupported;

    // Command decode; every access is answered one cycle later.
    // Nothing here spans two cycles, so commands may come back to back.
    // A refused code changes no state; the host learns of it from the flag.
    always_comb begin
        next_primary = primary_bus_address_base;
        next_secondary = secondary_bus_address_base;
        next_unlocked = unlocked;
        next_rdata = cmd_rdata;
        next_done = cmd_valid;
        next_unsupported = 1'b0;
        if (cmd_valid) begin
            unique case (cmd_code)
                CMD_PRIMARY_BASE: begin
                    if (cmd_write) begin
                        next_primary = cmd_wdata[7:0];
                    end else begin
                        next_rdata = {8'h00, primary_bus_address_base};
                    end
                end
                CMD_SECONDARY_BASE: begin
                    if (cmd_write) begin
                        next_secondary = cmd_wdata[7:0];
                    end else begin
                        next_rdata = {8'h00, secondary_bus_address_base};
                    end
                end
                CMD_UNLOCK_PASSWORD: begin
                    if (cmd_write) begin
                        // Any other value closes the memory again
                        next_unlocked = (cmd_wdata == UNLOCK_PASSWORD_CODE);
                    end else begin
                        // Write-only: the code is never echoed back
                        next_rdata = 16'h0000;
                    end
                end
                default: begin
                    next_rdata = 16'h0000;
                    next_unsupported = 1'b1;
                end
            endcase
        end
    end

    // Reset loads the base defaults and closes the memory again
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            primary_bus_address_base <= PRIMARY_BASE_RESET;
            secondary_bus_address_base <= SECONDARY_BASE_RESET;
            unlocked <= 1'b0;
            cmd_rdata <= 16'h0000;
            cmd_done <= 1'b0;
            cmd_unsupported <= 1'b0;
        end else begin
            primary_bus_address_base <= next_primary;
            secondary_bus_address_base <= next_secondary;
            unlocked <= next_unlocked;
            cmd_rdata <= next_rdata;
            cmd_done <= next_done;
            cmd_unsupported <= next_unsupported;
        end
    end

    // Address assembly
    logic [ADDRESS_WIDTH-1:0] next_address;
    logic [7:0] selected_base;

    // Pick the base by the pin level and join it with the offset.
    // Only bits 6-4 of the base reach the address; the rest is kept for read-back.
    always_comb begin
        selected_base = held_floating ? secondary_bus_address_base
                                      : primary_bus_address_base;
        next_address = {selected_base[BASE_FIELD_MSB:BASE_FIELD_LSB],
                        held_offset};
    end

    // Base writes take effect on the address one cycle after the write lands.
    // The address is shown during settling too; users must wait for valid.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_address <= '0;
            bus_address_valid <= 1'b0;
        end else begin
            bus_address <= next_address;
            bus_address_valid <= (strap_state == STRAP_HELD);
        end
    end

    // The store engine must see this high before it writes memory.
    // Reset clears the lock, so every power cycle starts locked;
    // only a password write or reset moves it.
    assign nonvolatile_memory_unlocked = unlocked;
endmodule : bus_address_config
`default_nettype wire

// ### host_model.sv
`default_nettype none
module host_model (
    input wire logic clk,
    output logic cmd_valid = 1'b0,
    output logic cmd_write = 1'b0,
    output logic [7:0] cmd_code = 8'h00,
    output logic [15:0] cmd_wdata = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // One-cycle pulse; fields invert on release so stale values never look valid
    task automatic send(input logic w, logic [7:0] c, logic [15:0] d);
        @(posedge clk);
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} <= {1'b1, w, c, d};
        @(posedge clk);
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} <= {1'b0, ~w, ~c, ~d};
    endtask : send
endmodule : host_model
`default_nettype wire

// ### strap_sync.sv
`default_nettype none
module strap_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] stage_mid,
    output logic [WIDTH-1:0] stage_late
);
    logic [WIDTH-1:0] stage_first;
    logic [WIDTH-1:0] next_first;
    logic [WIDTH-1:0] next_mid;
    logic [WIDTH-1:0] next_late;

    // Shift chain; the first stage feeds only the second
    always_comb begin
        next_first = pin;
        next_mid = stage_first;
        next_late = stage_mid;
    end

    // Synchronous clear keeps the chain quiet during reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage_first <= '0;
            stage_mid <= '0;
            stage_late <= '0;
        end else begin
            stage_first <= next_first;
            stage_mid <= next_mid;
            stage_late <= next_late;
        end
    end
endmodule : strap_sync
`default_nettype wire

// ### testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import addr_cfg_pkg::*;
    logic clk, rst_n, voltage_setting_pin_floating, cmd_valid, cmd_write, cmd_done;
    logic cmd_unsupported, bus_address_valid, nonvolatile_memory_unlocked;
    logic [3:0] strap_offset;
    logic [6:0] bus_address;
    logic [7:0] cmd_code, code, base;
    logic [15:0] cmd_wdata, cmd_rdata;
    logic [17:0] e, exp_q[$];
    logic [31:0] seed;
    int err_count = 0, checks_done = 0, cycles = 0;
    bus_address_config u_bus_address_config (.*);
    host_model u_host_model (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input string n, input logic [16:0] s, x);
        checks_done++;
        if (s !== x) begin
            err_count++;
            $display("FAIL %s exp %h seen %h", n, x, s);
        end
    endtask : check
    task automatic lk(input logic x);
        check("lock", {16'h0000, nonvolatile_memory_unlocked}, {16'h0000, x});
    endtask : lk
    // Notes the expected answer, then issues the request
    task automatic cmd(input logic w, logic [7:0] c, logic [15:0] d, logic [16:0] x);
        exp_q.push_back({~w, x});
        u_host_model.send(w, c, d);
        #1;
    endtask : cmd
    task automatic stop_test;
        // Every noted answer must have arrived before the verdict
        check("pending", 17'(exp_q.size()), 17'h00000);
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Each answer meets the oldest note; the cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cmd_done === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check("resp", {cmd_unsupported, e[17] ? cmd_rdata : 16'h0000}, e[16:0]);
        end
        if (cycles == 2000) begin
            err_count++;
            stop_test;
        end
    end
    // One power-up per voltage pin state, with a random strap offset
    initial begin
        rst_n = 1'b0;
        strap_offset = 4'h0;
        voltage_setting_pin_floating = 1'b0;
        seed = 32'h01D7;
        for (int p = 0; p < 2; p++) begin
            seed = lfsr(seed);
            code = p ? CMD_SECONDARY_BASE : CMD_PRIMARY_BASE;
            base = p ? SECONDARY_BASE_RESET : PRIMARY_BASE_RESET;
            @(posedge clk);
            rst_n <= 1'b0;
            // Low seed bits differ between power-ups and from the cleared offset
            strap_offset <= seed[3:0];
            voltage_setting_pin_floating <= p[0];
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
            #1 lk(1'b0);
            cmd(1'b0, CMD_PRIMARY_BASE, seed[15:0], {9'h000, PRIMARY_BASE_RESET});
            cmd(1'b0, CMD_SECONDARY_BASE, seed[15:0], {9'h000, SECONDARY_BASE_RESET});
            cmd(1'b0, CMD_UNLOCK_PASSWORD, seed[15:0], 17'h00000);
            cmd(1'b0, 8'hA5, seed[15:0], 17'h10000);
            for (int i = 0; i < 200 && bus_address_valid !== 1'b1; i++) @(posedge clk);
            strap_offset <= ~seed[3:0];
            voltage_setting_pin_floating <= ~p[0];
            repeat (6) @(posedge clk);
            #1 check("addr", {9'h000, bus_address_valid, bus_address},
                {10'h001, base[6:4], seed[3:0]});
            cmd(1'b1, code, seed[15:0], 17'h00000);
            cmd(1'b0, code, 16'h0000, {9'h000, seed[7:0]});
            check("base", {10'h000, bus_address}, {10'h000, seed[6:4], seed[3:0]});
            cmd(1'b1, CMD_UNLOCK_PASSWORD, UNLOCK_PASSWORD_CODE, 17'h00000);
            lk(1'b1);
        end
        cmd(1'b1, CMD_UNLOCK_PASSWORD, ~UNLOCK_PASSWORD_CODE, 17'h00000);
        lk(1'b0);
        repeat (2) @(posedge clk);
        stop_test;
    end
endmodule : testbench
bind bus_address_config addr_cfg_chk u_addr_cfg_chk (.*);
`default_nettype wire
